// ==== pkg/gas_alarm_pkg.sv ====
// Constants shared by the gas alarm threshold logic.
// Assumes a 250 MHz core clock; times are held in ns and turned into counts.
package gas_alarm_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS        = 4;
  localparam int BLINK_HALF_NS = 250_000_000;  // 0.5 s blink period
  localparam int HOLD_NS       = 2_000_000_000;
  localparam int SEC_NS        = 1_000_000_000;
  localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_NS;
  localparam int HOLD_CYC       = HOLD_NS / CLK_NS;
  localparam int SEC_CYC        = SEC_NS / CLK_NS;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CFG   = 8'h00;
  localparam logic [7:0] OFS_FS    = 8'h04;
  localparam logic [7:0] OFS_LVL1  = 8'h08;
  localparam logic [7:0] OFS_LVL2  = 8'h0C;
  localparam logic [7:0] OFS_DWELL = 8'h10;
  localparam logic [7:0] OFS_SETUP = 8'h14;
  localparam logic [7:0] OFS_SPAN  = 8'h18;
  localparam logic [7:0] OFS_STAT  = 8'h1C;
  localparam logic [7:0] OFS_VALUE = 8'h20;
  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [11:0] CFG_RST   = 12'h318;  // Rising, relays used, no pulse, %LEL
  localparam logic [15:0] FS_RST    = 16'h0064;
  localparam logic [15:0] FS_MAX    = 16'h270F;
  localparam logic [15:0] LVL1_RST  = 16'h0014;
  localparam logic [15:0] LVL2_RST  = 16'h0028;
  localparam logic [4:0]  DWELL_RST = 5'h01;
  localparam logic [4:0]  DWELL_MAX = 5'h1E;
  localparam logic [6:0]  ADDR_RST  = 7'h01;
  localparam logic [6:0]  ADDR_MAX  = 7'h40;
  localparam logic [3:0]  CALI_MAX  = 4'hC;
  localparam logic [4:0]  SUPP_RST  = 5'h07;
  localparam logic [4:0]  SUPP_MAX  = 5'h14;
  localparam logic [6:0]  CODE_MAX  = 7'h63;
  localparam logic [15:0] SPAN_RST  = 16'h0032;
  localparam logic [1:0]  UNIT_LEL  = 2'h3;
  localparam logic [1:0]  MODE_LAST = 2'h3;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {LV_IDLE, LV_DWELL, LV_ACTIVE} level_t;
  typedef enum logic [1:0] {UI_MEASURE, UI_CODE, UI_MENU} ui_t;
endpackage : gas_alarm_pkg

// ==== logic/gas_alarm_threshold_logic.sv ====
// Alarm evaluation, indications and keypad/settings logic of a gas detector.
// Assumes readings and error/calibration reports from same-clock receiver
// logic; the four keys are raw pins and are synchronised here.
// Function
// - Over 110% of full scale blinks indication
// - Alarm only after full dwell time
// - Lamp blinks while dwelling, steady afterwards
// - Relay switches only after dwell elapses
// - Latching holds alarm and peak until reset
// - Non-latching alarm releases automatically
// - Sensor error flashes code, trouble lamp on
// - Function held 2 s opens code entry
// - Code 00..99, default 00, opens menu
// - Only four user menu modes selectable
// - Station address OFF or 1..64, default 1
// - Calibration interval OFF or 1..12 months
// - Suppression OFF or 1..20 %, default 7
// - Unit four choices default LEL, decimals four
// - Full scale 1..9999, default 100
// - Level one max 90%, defaults 20/40%
// - Per-level direction rising or falling, rising
// - Per-level relay use, default enabled
// - Per-level relay pulsing, default disabled
// - Span reference defaults to 50%
// - Calibration reports success or failure first
`timescale 1ns/1ps
`default_nettype none
module gas_alarm_threshold_logic #(
  parameter int BLINK_HALF = gas_alarm_pkg::BLINK_HALF_CYC,
  parameter int HOLD_TIME  = gas_alarm_pkg::HOLD_CYC,
  parameter int SEC_TIME   = gas_alarm_pkg::SEC_CYC
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  input  wire logic [15:0] CONC,
  input  wire logic        CONC_VALID,
  input  wire logic        SENSOR_ERR,
  input  wire logic [5:0]  ERR_CODE_IN,
  input  wire logic        CAL_DONE,
  input  wire logic        CAL_OK,
  input  wire logic        KEY_FUNCTION,
  input  wire logic        KEY_UP,
  input  wire logic        KEY_DOWN,
  input  wire logic        KEY_RESET,
  output logic      [1:0]  ALARM_LAMP,
  output logic      [1:0]  ALARM_RELAY,
  output logic             TROUBLE_LAMP,
  output logic             OVER_RANGE_SHOW,
  output logic             ERR_SHOW,
  output logic      [5:0]  ERR_CODE,
  output logic      [15:0] VALUE,
  output logic             CODE_BLANK,
  output logic      [6:0]  CODE_ENTRY,
  output logic             MENU_OPEN,
  output logic      [1:0]  MENU_MODE,
  output logic             CAL_GOOD,
  output logic             CAL_FAIL
);
  // ----------------------------------------------------------------
  // Settings registers
  // ----------------------------------------------------------------
  logic [11:0] cfg_q;   // 0 hold, 1-2 dir, 3-4 use, 5-6 pulse, 9:8 unit, 11:10 dp
  logic [15:0] fs_q, span_q, conc_q, peak_q;
  logic [15:0] lvl_q [2];
  logic [4:0]  dwell_q [2];
  logic [6:0]  db_q [2];
  logic [6:0]  addr_q, code_q;
  logic [3:0]  cali_q;
  logic [4:0]  supp_q;
  logic        wr_cfg, wr_fs, wr_l1, wr_l2, wr_dw, wr_set;
  assign wr_cfg = WR && ADDR == gas_alarm_pkg::OFS_CFG;
  assign wr_fs  = WR && ADDR == gas_alarm_pkg::OFS_FS;
  assign wr_l1  = WR && ADDR == gas_alarm_pkg::OFS_LVL1;
  assign wr_l2  = WR && ADDR == gas_alarm_pkg::OFS_LVL2;
  assign wr_dw  = WR && ADDR == gas_alarm_pkg::OFS_DWELL;
  assign wr_set = WR && ADDR == gas_alarm_pkg::OFS_SETUP;

  // Field within range: 0 means OFF where allowed, else lo..hi
  function automatic logic in_rng(input logic [15:0] v, input logic [15:0] hi,
                                  input logic off_ok);
    in_rng = (v == 16'h0000) ? off_ok : (v <= hi);
  endfunction : in_rng

  // Out-of-range writes leave the old field; levels are checked only against the full scale at write time
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cfg_q <= gas_alarm_pkg::CFG_RST;
      fs_q  <= gas_alarm_pkg::FS_RST;
      lvl_q[0] <= gas_alarm_pkg::LVL1_RST;
      lvl_q[1] <= gas_alarm_pkg::LVL2_RST;
      dwell_q[0] <= gas_alarm_pkg::DWELL_RST;
      dwell_q[1] <= gas_alarm_pkg::DWELL_RST;
      db_q[0] <= 7'h00;
      db_q[1] <= 7'h00;
      addr_q <= gas_alarm_pkg::ADDR_RST;
      cali_q <= 4'h0;
      supp_q <= gas_alarm_pkg::SUPP_RST;
      code_q <= 7'h00;
      span_q <= gas_alarm_pkg::SPAN_RST;
    end else begin
      if (wr_cfg) cfg_q <= WDATA[11:0];
      if (wr_fs && in_rng(WDATA[15:0], gas_alarm_pkg::FS_MAX, 1'b0))
        fs_q <= WDATA[15:0];
      if (wr_l1 && 32'(WDATA[15:0]) * 10 <= 32'(fs_q) * 9)
        lvl_q[0] <= WDATA[15:0];
      if (wr_l2 && WDATA[15:0] <= fs_q) lvl_q[1] <= WDATA[15:0];
      if (wr_dw) begin
        if (WDATA[4:0] <= gas_alarm_pkg::DWELL_MAX) dwell_q[0] <= WDATA[4:0];
        if (WDATA[12:8] <= gas_alarm_pkg::DWELL_MAX) dwell_q[1] <= WDATA[12:8];
        if (WDATA[22:16] <= gas_alarm_pkg::CODE_MAX) db_q[0] <= WDATA[22:16];
        if (WDATA[30:24] <= gas_alarm_pkg::CODE_MAX) db_q[1] <= WDATA[30:24];
      end
      if (wr_set) begin
        if (in_rng({9'h000, WDATA[6:0]}, {9'h000, gas_alarm_pkg::ADDR_MAX}, 1'b1))
          addr_q <= WDATA[6:0];
        if (in_rng({12'h000, WDATA[11:8]}, {12'h000, gas_alarm_pkg::CALI_MAX}, 1'b1))
          cali_q <= WDATA[11:8];
        if (in_rng({11'h000, WDATA[20:16]}, {11'h000, gas_alarm_pkg::SUPP_MAX}, 1'b1))
          supp_q <= WDATA[20:16];
        if (WDATA[30:24] <= gas_alarm_pkg::CODE_MAX) code_q <= WDATA[30:24];
      end
      if (WR && ADDR == gas_alarm_pkg::OFS_SPAN) span_q <= WDATA[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Key synchronisers and edges
  // ----------------------------------------------------------------
  logic [3:0] key_m_q, key_s_q, key_p_q;
  logic       fn_fall, up_rise, dn_rise, rst_rise;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      key_m_q <= 4'h0;
      key_s_q <= 4'h0;
      key_p_q <= 4'h0;
    end else begin
      key_m_q <= {KEY_RESET, KEY_DOWN, KEY_UP, KEY_FUNCTION};
      key_s_q <= key_m_q;
      key_p_q <= key_s_q;
    end
  end
  assign fn_fall  = !key_s_q[0] && key_p_q[0];
  assign up_rise  = key_s_q[1] && !key_p_q[1];
  assign dn_rise  = key_s_q[2] && !key_p_q[2];
  assign rst_rise = key_s_q[3] && !key_p_q[3];

  // ----------------------------------------------------------------
  // Blink base and reading capture
  // ----------------------------------------------------------------
  logic [31:0] blink_cnt_q;
  logic        blink_q;
  // One shared phase so all flashing indications stay in step
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      blink_cnt_q <= 32'h0;
      blink_q     <= 1'b0;
    end else if (blink_cnt_q == 32'(BLINK_HALF - 1)) begin
      blink_cnt_q <= 32'h0;
      blink_q     <= !blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) conc_q <= 16'h0000;
    else if (CONC_VALID) conc_q <= CONC;
  end

  // ----------------------------------------------------------------
  // Alarm levels
  // ----------------------------------------------------------------
  gas_alarm_pkg::level_t lv_q [2];
  logic [39:0] dw_cnt_q [2];
  logic [1:0]  trip, still, latched;
  logic [39:0] dw_target [2];
  logic        hold;
  assign hold = cfg_q[0];

  // Trip and keep-on tests; release needs the dead band to be crossed
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      dw_target[i] = 40'(dwell_q[i]) * 40'(SEC_TIME);
      if (!cfg_q[1+i]) begin
        trip[i]  = conc_q > lvl_q[i];
        still[i] = 17'(conc_q) + 17'(db_q[i]) >= 17'(lvl_q[i]);
      end else begin
        trip[i]  = conc_q < lvl_q[i];
        still[i] = 17'(conc_q) <= 17'(lvl_q[i]) + 17'(db_q[i]);
      end
      latched[i] = lv_q[i] == gas_alarm_pkg::LV_ACTIVE && hold;
    end
  end

  // Each level runs its own dwell counter and state
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < 2; i++) begin
        lv_q[i]     <= gas_alarm_pkg::LV_IDLE;
        dw_cnt_q[i] <= 40'h0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        case (lv_q[i])
          gas_alarm_pkg::LV_IDLE: begin
            dw_cnt_q[i] <= 40'h0;
            if (trip[i]) lv_q[i] <= gas_alarm_pkg::LV_DWELL;
          end
          gas_alarm_pkg::LV_DWELL: begin
            if (!trip[i]) begin
              lv_q[i] <= gas_alarm_pkg::LV_IDLE;
            end else if (dw_cnt_q[i] >= dw_target[i]) begin
              lv_q[i] <= gas_alarm_pkg::LV_ACTIVE;
            end else begin
              dw_cnt_q[i] <= dw_cnt_q[i] + 40'h1;
            end
          end
          gas_alarm_pkg::LV_ACTIVE: begin
            if (hold) begin
              if (rst_rise && !still[i]) lv_q[i] <= gas_alarm_pkg::LV_IDLE;
            end else if (!still[i]) begin
              lv_q[i] <= gas_alarm_pkg::LV_IDLE;
            end
          end
          default: lv_q[i] <= gas_alarm_pkg::LV_IDLE;
        endcase
      end
    end
  end

  // Lamp and relay drive
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ALARM_LAMP  <= 2'b00;
      ALARM_RELAY <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        ALARM_LAMP[i] <= lv_q[i] == gas_alarm_pkg::LV_ACTIVE ||
                         (lv_q[i] == gas_alarm_pkg::LV_DWELL && blink_q);
        ALARM_RELAY[i] <= lv_q[i] == gas_alarm_pkg::LV_ACTIVE && cfg_q[3+i] &&
                          (!cfg_q[5+i] || blink_q);
      end
    end
  end

  // ----------------------------------------------------------------
  // Reported value, over-range and trouble
  // ----------------------------------------------------------------
  logic suppress, over;
  // Readings at or below the suppression share of full scale read as zero
  assign suppress = supp_q != 5'h00 &&
                    32'(conc_q) * 100 <= 32'(fs_q) * 32'(supp_q);
  assign over     = 32'(conc_q) * 10 > 32'(fs_q) * 11;

  // Peak is only tracked while a latched alarm stands
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      peak_q <= 16'h0000;
    end else if (latched != 2'b00) begin
      if (conc_q > peak_q) peak_q <= conc_q;
    end else begin
      peak_q <= conc_q;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      VALUE           <= 16'h0000;
      OVER_RANGE_SHOW <= 1'b0;
      TROUBLE_LAMP    <= 1'b0;
      ERR_SHOW        <= 1'b0;
      ERR_CODE        <= 6'h00;
    end else begin
      VALUE           <= latched != 2'b00 ? peak_q : (suppress ? 16'h0000 : conc_q);
      OVER_RANGE_SHOW <= over && blink_q;
      TROUBLE_LAMP    <= SENSOR_ERR;
      ERR_SHOW        <= SENSOR_ERR && blink_q;
      ERR_CODE        <= SENSOR_ERR ? ERR_CODE_IN : 6'h00;
    end
  end

  // ----------------------------------------------------------------
  // Calibration result, shown for the hold time
  // ----------------------------------------------------------------
  logic [31:0] res_cnt_q;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      CAL_GOOD  <= 1'b0;
      CAL_FAIL  <= 1'b0;
      res_cnt_q <= 32'h0;
    end else if (CAL_DONE) begin
      CAL_GOOD  <= CAL_OK;
      CAL_FAIL  <= !CAL_OK;
      res_cnt_q <= 32'(HOLD_TIME);
    end else if (res_cnt_q != 32'h0) begin
      res_cnt_q <= res_cnt_q - 32'h1;
    end else begin
      CAL_GOOD <= 1'b0;
      CAL_FAIL <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Keypad: long press, code entry, mode selection
  // ----------------------------------------------------------------
  gas_alarm_pkg::ui_t ui_q;
  logic [31:0] press_q;
  logic        long_hit;
  assign long_hit = key_s_q[0] && press_q == 32'(HOLD_TIME - 1);

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) press_q <= 32'h0;
    else if (!key_s_q[0]) press_q <= 32'h0;
    else if (press_q != 32'(HOLD_TIME)) press_q <= press_q + 32'h1;
  end

  // A short press is the release of the function key
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ui_q       <= gas_alarm_pkg::UI_MEASURE;
      CODE_ENTRY <= 7'h00;
      MENU_MODE  <= 2'h0;
    end else begin
      case (ui_q)
        gas_alarm_pkg::UI_MEASURE: begin
          if (long_hit) begin
            ui_q       <= gas_alarm_pkg::UI_CODE;
            CODE_ENTRY <= 7'h00;
          end
        end
        gas_alarm_pkg::UI_CODE: begin
          if (up_rise) begin
            CODE_ENTRY <= CODE_ENTRY == gas_alarm_pkg::CODE_MAX ? 7'h00 : CODE_ENTRY + 7'h1;
          end else if (dn_rise) begin
            CODE_ENTRY <= CODE_ENTRY == 7'h00 ? gas_alarm_pkg::CODE_MAX : CODE_ENTRY - 7'h1;
          end else if (fn_fall && press_q < 32'(HOLD_TIME)) begin
            ui_q      <= CODE_ENTRY == code_q ? gas_alarm_pkg::UI_MENU
                                              : gas_alarm_pkg::UI_MEASURE;
            MENU_MODE <= 2'h0;
          end else if (rst_rise) begin
            ui_q <= gas_alarm_pkg::UI_MEASURE;
          end
        end
        gas_alarm_pkg::UI_MENU: begin
          // The 2-bit index can only name the four user modes
          if (up_rise) MENU_MODE <= MENU_MODE + 2'h1;
          else if (dn_rise) MENU_MODE <= MENU_MODE - 2'h1;
          else if (rst_rise) ui_q <= gas_alarm_pkg::UI_MEASURE;
        end
        default: ui_q <= gas_alarm_pkg::UI_MEASURE;
      endcase
    end
  end
  assign CODE_BLANK = ui_q == gas_alarm_pkg::UI_CODE && CODE_ENTRY == 7'h00;
  assign MENU_OPEN  = ui_q == gas_alarm_pkg::UI_MENU;

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 32'h0;
    end else if (RD) begin
      case (ADDR)
        gas_alarm_pkg::OFS_CFG:   RDATA <= {20'h0, cfg_q};
        gas_alarm_pkg::OFS_FS:    RDATA <= {16'h0, fs_q};
        gas_alarm_pkg::OFS_LVL1:  RDATA <= {16'h0, lvl_q[0]};
        gas_alarm_pkg::OFS_LVL2:  RDATA <= {16'h0, lvl_q[1]};
        gas_alarm_pkg::OFS_DWELL: RDATA <= {1'b0, db_q[1], 1'b0, db_q[0], 3'h0, dwell_q[1],
                                            3'h0, dwell_q[0]};
        gas_alarm_pkg::OFS_SETUP: RDATA <= {1'b0, code_q, 3'h0, supp_q, 4'h0, cali_q,
                                            1'b0, addr_q};
        gas_alarm_pkg::OFS_SPAN:  RDATA <= {16'h0, span_q};
        gas_alarm_pkg::OFS_STAT:  RDATA <= {22'h0, CAL_FAIL, CAL_GOOD, SENSOR_ERR, over,
                                            2'(ui_q), lv_q[1], lv_q[0]};
        gas_alarm_pkg::OFS_VALUE: RDATA <= {16'h0, VALUE};
        default:                  RDATA <= 32'h0;
      endcase
    end else begin
      RDATA <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  sequence s_dwelling(int i);
    lv_q[i] == gas_alarm_pkg::LV_DWELL;
  endsequence
  sequence s_active(int i);
    lv_q[i] == gas_alarm_pkg::LV_ACTIVE;
  endsequence

  chk_over_range_show: assert property (OVER_RANGE_SHOW |-> $past(over) && $past(blink_q))
    else $error("over-range shown without cause");
  chk_dwell_full_time: assert property ($rose(lv_q[0] == gas_alarm_pkg::LV_ACTIVE) |->
    $past(dw_cnt_q[0]) >= $past(dw_target[0]))
    else $error("alarm one active before dwell elapsed");
  chk_lamp_steady_on: assert property (s_active(0) |=> ALARM_LAMP[0])
    else $error("lamp not steady on active alarm");
  chk_lamp_dwell_blink: assert property (s_dwelling(1) ##1 s_dwelling(1) |->
    ALARM_LAMP[1] == $past(blink_q))
    else $error("lamp not following blink while dwelling");
  chk_relay_after_dwell: assert property ($rose(ALARM_RELAY[0]) |->
    $past(lv_q[0] == gas_alarm_pkg::LV_ACTIVE))
    else $error("relay on before dwell elapsed");
  chk_latch_hold: assert property (s_active(0) and (hold && !rst_rise) |=> s_active(0))
    else $error("latched alarm dropped without reset key");
  chk_auto_release: assert property (!hold && s_active(0) && !still[0] |=>
    lv_q[0] == gas_alarm_pkg::LV_IDLE)
    else $error("unlatched alarm not released");
  chk_trouble_lamp: assert property (SENSOR_ERR |=> TROUBLE_LAMP && ERR_CODE == $past(ERR_CODE_IN))
    else $error("sensor error not indicated");
  chk_code_entry: assert property (ui_q == gas_alarm_pkg::UI_MEASURE && long_hit |=>
    ui_q == gas_alarm_pkg::UI_CODE && CODE_ENTRY == 7'h00)
    else $error("long press did not open code entry");
  chk_menu_open: assert property ($rose(MENU_OPEN) |-> $past(CODE_ENTRY) == code_q)
    else $error("menu opened with wrong code");
endmodule : gas_alarm_threshold_logic
`default_nettype wire

// ==== verification/cartridge_model.sv ====
// Sensor cartridge stand-in: streams one reading every fourth cycle.
// Assumes the bench sets the level, fault flag and fault number.
`timescale 1ns/1ps
`default_nettype none
module cartridge_model (
  input  wire logic        clk,
  input  wire logic [15:0] level,
  input  wire logic        fault,
  input  wire logic [5:0]  fault_num,
  output logic      [15:0] conc,
  output logic             conc_valid,
  output logic             sensor_err,
  output logic      [5:0]  err_code
);
  logic [1:0] tick_q = 2'h0;
  initial conc_valid = 1'b0;
  initial sensor_err = 1'b0;
  // Between strobes the bus shows junk, so a held value is never trusted
  always @(posedge clk) begin
    tick_q     <= tick_q + 2'h1;
    conc_valid <= (tick_q == 2'h3);
    conc       <= (tick_q == 2'h3) ? level : ~level;
    sensor_err <= fault;
    err_code   <= fault ? fault_num : ~fault_num;
  end
endmodule : cartridge_model
`default_nettype wire

// ==== verification/test_gas_alarm_threshold_logic.sv ====
// Self-checking bench for the gas alarm threshold logic.
// Assumes short blink, hold and second counts set at the instance.
`timescale 1ns/1ps
`default_nettype none
module test_gas_alarm_threshold_logic;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, cal_done = 1'b0, cal_ok = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  keys = 4'h0;
  logic [15:0] level = 16'h0, conc, value;
  logic        fault = 1'b0, cvalid, serr, trouble, over, eshow, blank, menu, good, fail;
  logic [5:0]  fnum = 6'h0, ecode_in, ecode;
  logic [1:0]  lamp, relay, mode;
  logic [6:0]  entry;
  logic [5:0]  seen1, seen0;
  int          bad_count = 0, n_tests = 0;
  cartridge_model cart_u (.clk(clk), .level(level), .fault(fault), .fault_num(fnum),
    .conc(conc), .conc_valid(cvalid), .sensor_err(serr), .err_code(ecode_in));
  gas_alarm_threshold_logic #(.BLINK_HALF(4), .HOLD_TIME(20), .SEC_TIME(10)) dut_u (
    .CORE_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .CONC(conc), .CONC_VALID(cvalid), .SENSOR_ERR(serr), .ERR_CODE_IN(ecode_in),
    .CAL_DONE(cal_done), .CAL_OK(cal_ok), .KEY_FUNCTION(keys[0]), .KEY_UP(keys[1]),
    .KEY_DOWN(keys[2]), .KEY_RESET(keys[3]), .ALARM_LAMP(lamp), .ALARM_RELAY(relay),
    .TROUBLE_LAMP(trouble), .OVER_RANGE_SHOW(over), .ERR_SHOW(eshow), .ERR_CODE(ecode),
    .VALUE(value), .CODE_BLANK(blank), .CODE_ENTRY(entry), .MENU_OPEN(menu),
    .MENU_MODE(mode), .CAL_GOOD(good), .CAL_FAIL(fail));
  always #2 clk = ~clk;
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(exp, rdata);
  endtask : rd_chk
  // Sample blinking outputs; a steady line would miss one level
  task automatic watch(input int n);
    seen1 = 6'h00;
    seen0 = 6'h00;
    repeat (n) begin
      cyc(1);
      seen1 = seen1 | {eshow, over, relay, lamp};
      seen0 = seen0 | ~{eshow, over, relay, lamp};
    end
  endtask : watch
  task automatic alarm(input logic [15:0] l, input int n);
    @(posedge clk) level <= l;
    cyc(n);
  endtask : alarm
  // Key pressed for n cycles, then six cycles for the synchronised release
  task automatic press(input int k, input int n);
    @(posedge clk) keys[k] <= 1'b1;
    repeat (n) @(posedge clk);
    keys[k] <= 1'b0;
    cyc(6);
  endtask : press
  task automatic cal(input logic ok);
    @(posedge clk) cal_done <= 1'b1;
    cal_ok <= ok;
    @(posedge clk) cal_done <= 1'b0;
    cyc(2);
  endtask : cal
  task automatic complete_run();
    $display("Mismatches %0d of %0d comparisons", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_chk(gas_alarm_pkg::OFS_CFG, 32'h318);
    rd_chk(gas_alarm_pkg::OFS_FS, 32'h64);
    rd_chk(gas_alarm_pkg::OFS_LVL2, 32'h28);
    rd_chk(gas_alarm_pkg::OFS_DWELL, 32'h101);
    rd_chk(gas_alarm_pkg::OFS_SPAN, 32'h32);
    rd_chk(8'h40, 32'h0);
    wr_reg(gas_alarm_pkg::OFS_SETUP, 32'h00150D41);
    rd_chk(gas_alarm_pkg::OFS_SETUP, 32'h00070001);
    wr_reg(gas_alarm_pkg::OFS_FS, 32'h2710);
    rd_chk(gas_alarm_pkg::OFS_FS, 32'h64);
    wr_reg(gas_alarm_pkg::OFS_LVL1, 32'h5B);
    rd_chk(gas_alarm_pkg::OFS_LVL1, 32'h14);
    // Rising alarm on level one only, then automatic release
    alarm(16'd30, 8);
    chk(2'b00, relay);
    watch(7);
    chk(2'b11, {seen1[0], seen0[0]});
    cyc(10);
    chk(4'b0101, {relay, lamp});
    chk(16'd30, value);
    alarm(16'd5, 10);
    chk(2'b00, relay);
    chk(16'd0, value);
    // Latched alarm holds the peak until the reset key
    wr_reg(gas_alarm_pkg::OFS_CFG, 32'h319);
    alarm(16'd30, 25);
    alarm(16'd5, 10);
    chk(18'h1001E, {relay, value});
    press(3, 4);
    chk(2'b00, relay);
    // Falling direction on level two, relay use off on level one
    wr_reg(gas_alarm_pkg::OFS_CFG, 32'h314);
    alarm(16'd30, 25);
    chk(4'b1011, {relay, lamp});
    wr_reg(gas_alarm_pkg::OFS_CFG, 32'h338);
    alarm(16'd50, 25);
    watch(8);
    chk(2'b11, {seen1[2], seen0[2]});
    alarm(16'd110, 8);
    watch(8);
    chk(1'b0, seen1[4]);
    alarm(16'd111, 8);
    watch(8);
    chk(2'b11, {seen1[4], seen0[4]});
    @(posedge clk) fault <= 1'b1;
    fnum <= 6'h22;
    watch(10);
    chk(8'hE2, {trouble, seen1[5], ecode});
    @(posedge clk) fault <= 1'b0;
    // Long function press opens code entry; its own release is ignored
    @(posedge clk) keys[0] <= 1'b1;
    cyc(30);
    chk(8'h80, {blank, entry});
    @(posedge clk) keys[0] <= 1'b0;
    cyc(6);
    chk(1'b0, menu);
    // A short press with the default code opens the menu
    press(0, 4);
    chk(1'b1, menu);
    press(1, 4);
    chk(2'h1, mode);
    cal(1'b0);
    chk(2'b01, {good, fail});
    cal(1'b1);
    chk(2'b10, {good, fail});
    cyc(25);
    chk(2'b00, {good, fail});
    complete_run();
  end
endmodule : test_gas_alarm_threshold_logic
`default_nettype wire
